// ===== verilog/code_memory_security_lock.sv
/*
 code memory security lock: lock bits, 64-byte encryption key,
 verify, program and table-read gating, with an apb slave for the programmer side.
 assumes mem_rdata is the code byte at mem_addr in the same cycle, tread_* come from logic on mclk,
 ext_access_pin is asynchronous, por_n is a power-on reset that erases the non-volatile image.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sec_lock_regs.svh"

module code_memory_security_lock
	import sec_lock_pkg::*;
#(
	parameter int CODE_KB = 4
) (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        por_n,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_access_pin,
	output logic             acc_eff,
	output logic      [15:0] mem_addr,
	input  wire logic [7:0]  mem_rdata,
	output logic             prog_strobe,
	output logic      [7:0]  prog_data,
	input  wire logic        tread_req,
	input  wire logic        tread_ext,
	input  wire logic [15:0] tread_addr,
	output logic             tread_done,
	output logic             tread_block
);
	localparam logic [15:0] CODE_TOP  = (CODE_KB == 8) ? `SL_CODE_TOP_8K : `SL_CODE_TOP_4K;
	localparam logic [15:0] KEY_BASE  = (CODE_KB == 8) ? `SL_KEY_BASE_8K : `SL_KEY_BASE_4K;
	localparam logic [15:0] KEY_TOP   = (CODE_KB == 8) ? `SL_KEY_TOP_8K : `SL_KEY_TOP_4K;
	localparam logic [15:0] LOCK_ADDR = (CODE_KB == 8) ? `SL_LOCK_ADDR_8K : `SL_LOCK_ADDR_4K;
	localparam int          KEY_BYTES = `SL_KEY_BYTES;

	function automatic lock_level_e lock_level(input logic loaded, input logic one, input logic two);
		if (!loaded || (!one && !two)) begin
			lock_level = LOCK_FULL;
		end else if (!one) begin
			lock_level = LOCK_PART;
		end else begin
			lock_level = LOCK_NONE;
		end
	endfunction

	lock_state_s s;
	lock_state_s next_s;
	logic [7:0]  key [KEY_BYTES];
	logic [1:0]  lock_nv;
	logic        key_we;
	logic        lock_we;
	logic [5:0]  key_idx;
	logic [7:0]  key_sel;
	logic [7:0]  verify_byte;
	lock_level_e lvl;
	logic        setup;
	logic        wr;
	logic        refused_set;

	assign key_idx = s.addr[5:0];
	assign key_sel = key[key_idx];
	assign lvl     = lock_level(s.loaded, s.lock_one, s.lock_two);
	assign setup   = psel & ~penable;
	assign wr      = psel & penable & pwrite & s.pready;

	// erased key is all ones, so xnor passes plain code through
	always_comb begin
		if (lvl == LOCK_FULL) begin
			verify_byte = `SL_VERIFY_OFF_VAL;
		end else begin
			verify_byte = mem_rdata ~^ key_sel;
		end
	end

	always_comb begin
		next_s             = s;
		key_we             = 1'b0;
		lock_we            = 1'b0;
		refused_set        = 1'b0;
		next_s.acc_s1      = ext_access_pin;
		next_s.acc_s2      = s.acc_s1;
		next_s.prog_strobe = 1'b0;
		if (!s.loaded) begin
			if (s.load_cnt == `SL_LOAD_CYCLES) begin
				next_s.loaded   = 1'b1;
				next_s.lock_one = lock_nv[`SL_LOCK_ONE_BIT];
				next_s.lock_two = lock_nv[`SL_LOCK_TWO_BIT];
				next_s.acc_lat  = s.acc_s2;
			end else begin
				next_s.load_cnt = s.load_cnt + 2'h1;
			end
		end
		next_s.acc_eff     = (lvl != LOCK_NONE) ? s.acc_lat : s.acc_s2;
		next_s.tread_done  = tread_req;
		next_s.tread_block = tread_req & tread_ext & (lvl != LOCK_NONE)
			& (tread_addr <= CODE_TOP);
		next_s.pready  = setup;
		next_s.pslverr = 1'b0;
		next_s.prdata  = 32'h0000_0000;
		if (setup) begin
			if (paddr == `SL_OFF_ADDR) begin
				next_s.prdata[15:0] = s.addr;
			end else if (paddr == `SL_OFF_PROG) begin
				next_s.prdata = 32'h0000_0000;
			end else if (paddr == `SL_OFF_VDATA) begin
				next_s.prdata[7:0] = verify_byte;
			end else if (paddr == `SL_OFF_STATUS) begin
				next_s.prdata[`SL_ST_LOCK_ONE]   = ~s.lock_one;
				next_s.prdata[`SL_ST_LOCK_TWO]   = ~s.lock_two;
				next_s.prdata[`SL_ST_PIN_LAT]    = s.acc_lat;
				next_s.prdata[`SL_ST_VERIFY_OFF] = (lvl == LOCK_FULL);
				next_s.prdata[`SL_ST_REFUSED]    = s.refused;
				next_s.prdata[`SL_ST_LOADED]     = s.loaded;
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
		if (wr) begin
			if (paddr == `SL_OFF_ADDR) begin
				next_s.addr = pwdata[15:0];
			end else if (paddr == `SL_OFF_PROG) begin
				if (lvl != LOCK_NONE) begin
					refused_set = 1'b1;
				end else if (s.addr <= CODE_TOP) begin
					next_s.prog_strobe = 1'b1;
					next_s.prog_data   = pwdata[7:0];
				end else if (s.addr >= KEY_BASE && s.addr <= KEY_TOP) begin
					key_we = 1'b1;
				end else if (s.addr == LOCK_ADDR) begin
					lock_we = 1'b1;
				end else begin
					refused_set = 1'b1;
				end
			end else if (paddr == `SL_OFF_STATUS && pwdata[`SL_ST_REFUSED]) begin
				next_s.refused = 1'b0;
			end
		end
		if (refused_set) begin
			next_s.refused = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// non-volatile image: programming only clears bits, survives resetn
	always_ff @(posedge mclk or negedge por_n) begin
		if (!por_n) begin
			for (int i = 0; i < KEY_BYTES; i++) begin
				key[i] <= `SL_KEY_ERASED;
			end
			lock_nv <= `SL_LOCK_ERASED;
		end else begin
			if (key_we) begin
				key[key_idx] <= key_sel & pwdata[7:0];
			end
			if (lock_we) begin
				lock_nv <= lock_nv & pwdata[1:0];
			end
		end
	end

	assign prdata      = s.prdata;
	assign pready      = s.pready;
	assign pslverr     = s.pslverr;
	assign acc_eff     = s.acc_eff;
	assign mem_addr    = s.addr;
	assign prog_strobe = s.prog_strobe;
	assign prog_data   = s.prog_data;
	assign tread_done  = s.tread_done;
	assign tread_block = s.tread_block;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	chk_lock_stable: assert property (s.loaded |=> $stable(s.lock_one) && $stable(s.lock_two))
		else $error("lock bits changed after load");
	chk_load_time: assert property ($rose(s.loaded) |-> $past(s.load_cnt) == `SL_LOAD_CYCLES)
		else $error("lock bits loaded at wrong time");
	chk_pin_latched: assert property (s.loaded && lvl != LOCK_NONE
		|=> acc_eff == s.acc_lat && $stable(s.acc_lat))
		else $error("external access not held latched");
	chk_tread_blocked: assert property (tread_req && tread_ext && tread_addr <= CODE_TOP
		&& lvl != LOCK_NONE |=> tread_block && tread_done)
		else $error("external table read reached internal code");
	chk_tread_open: assert property (tread_req && lvl == LOCK_NONE |=> !tread_block)
		else $error("table read blocked while unlocked");
	chk_verify_plain: assert property (setup && paddr == `SL_OFF_VDATA && lvl == LOCK_NONE
		&& key_sel == `SL_KEY_ERASED |=> prdata[7:0] == $past(mem_rdata))
		else $error("unlocked verify not plain");
	chk_verify_crypt: assert property (setup && paddr == `SL_OFF_VDATA && lvl != LOCK_FULL
		|=> prdata[7:0] == ($past(mem_rdata) ~^ $past(key_sel)))
		else $error("verify not encrypted by key");
	chk_verify_off: assert property (setup && paddr == `SL_OFF_VDATA && lvl == LOCK_FULL
		|=> prdata == 32'h0000_0000)
		else $error("verify not disabled");
	chk_prog_refused: assert property (wr && paddr == `SL_OFF_PROG && lvl != LOCK_NONE
		|=> !prog_strobe && s.refused)
		else $error("programming not refused");
	chk_prog_code: assert property (wr && paddr == `SL_OFF_PROG && lvl == LOCK_NONE
		&& s.addr <= CODE_TOP |=> prog_strobe ##1 !prog_strobe)
		else $error("code programming strobe wrong");
	cov_verify_crypt: cover property (setup && paddr == `SL_OFF_VDATA && key_sel != 8'hFF);
	cov_tread_block: cover property (tread_block);
	cov_prog_refused: cover property ($rose(s.refused));
	cov_full_lock: cover property (s.loaded && lvl == LOCK_FULL);
endmodule

`default_nettype wire

// ===== verilog/sec_lock_regs.svh
/*
 defines for the code memory security lock: apb offsets, image map, field positions, reset values.
 assumes inclusion by bare name from any design file.
*/
`ifndef SEC_LOCK_REGS_SVH
`define SEC_LOCK_REGS_SVH

`define SL_OFF_ADDR       12'h000
`define SL_OFF_PROG       12'h004
`define SL_OFF_VDATA      12'h008
`define SL_OFF_STATUS     12'h00C

`define SL_CODE_TOP_4K    16'h0FFF
`define SL_KEY_BASE_4K    16'h1000
`define SL_KEY_TOP_4K     16'h103F
`define SL_LOCK_ADDR_4K   16'h1040
`define SL_CODE_TOP_8K    16'h1FFF
`define SL_KEY_BASE_8K    16'h2000
`define SL_KEY_TOP_8K     16'h203F
`define SL_LOCK_ADDR_8K   16'h2040

`define SL_LOCK_ONE_BIT   0
`define SL_LOCK_TWO_BIT   1
`define SL_ST_LOCK_ONE    0
`define SL_ST_LOCK_TWO    1
`define SL_ST_PIN_LAT     2
`define SL_ST_VERIFY_OFF  3
`define SL_ST_REFUSED     4
`define SL_ST_LOADED      5

`define SL_KEY_ERASED     8'hFF
`define SL_KEY_BYTES      64
`define SL_LOCK_ERASED    2'h3
`define SL_LOAD_CYCLES    2'h2
`define SL_VERIFY_OFF_VAL 8'h00

`endif

// ===== verilog/sec_lock_pkg.sv
/*
 types for the code memory security lock.
 assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package sec_lock_pkg;
	typedef enum logic [1:0] {LOCK_NONE, LOCK_PART, LOCK_FULL} lock_level_e;

	typedef struct packed {
		logic        acc_s1;
		logic        acc_s2;
		logic        acc_lat;
		logic [1:0]  load_cnt;
		logic        loaded;
		logic        lock_one;
		logic        lock_two;
		logic [15:0] addr;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        refused;
		logic        prog_strobe;
		logic [7:0]  prog_data;
		logic        tread_done;
		logic        tread_block;
		logic        acc_eff;
	} lock_state_s;
endpackage
`default_nettype wire

// ===== verif/code_mem_model.sv
/*
 code memory model behind the lock block.
 assumes mem_addr and prog_strobe come from the block on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module code_mem_model (
	input  wire logic        mclk,
	input  wire logic [15:0] mem_addr,
	input  wire logic        prog_strobe,
	input  wire logic [7:0]  prog_data,
	output logic      [7:0]  mem_rdata
);
	logic [7:0] mem [0:4095];
	initial begin
		for (int i = 0; i < 4096; i++)
			mem[i] = i[7:0] ^ 8'h5A;
	end
	assign mem_rdata = mem[mem_addr[11:0]];
	always @(posedge mclk) begin
		if (prog_strobe && mem_addr <= 16'h0FFF) mem[mem_addr[11:0]] <= prog_data;
	end
endmodule
`default_nettype wire

// ===== verif/test_code_memory_security_lock.sv
/*
 self-checking bench for the code memory security lock.
 assumes the code memory model and a 10 MHz mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module test_code_memory_security_lock;
	logic        mclk, resetn, por_n, psel, penable, pwrite, pin, prog_strobe;
	logic        pready, pslverr, rerr, acc_eff, tread_req, tread_ext, tread_done, tread_block;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] mem_addr, tread_addr;
	logic [7:0]  mem_rdata, prog_data;
	int          fail_count, num_checks;
	logic [23:0] rows [3] = '{24'h00005A, 24'h0FFFA5, 24'h012379};

	code_memory_security_lock code_memory_security_lock_inst (.mclk(mclk), .resetn(resetn),
		.por_n(por_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_access_pin(pin), .acc_eff(acc_eff), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
		.prog_strobe(prog_strobe), .prog_data(prog_data), .tread_req(tread_req),
		.tread_ext(tread_ext), .tread_addr(tread_addr), .tread_done(tread_done),
		.tread_block(tread_block));
	code_mem_model code_mem_model_inst (.mclk(mclk), .mem_addr(mem_addr),
		.prog_strobe(prog_strobe), .prog_data(prog_data), .mem_rdata(mem_rdata));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic prog(input logic [15:0] a, input logic [7:0] d);
		apb(1'b1, 12'h000, {16'h0, a});
		apb(1'b1, 12'h004, {24'h0, d});
	endtask
	task automatic vread(input logic [15:0] a);
		apb(1'b1, 12'h000, {16'h0, a});
		apb(1'b0, 12'h008, 32'h0);
	endtask
	task automatic tr(input logic ext, input logic [15:0] a);
		@(posedge mclk);
		tread_req <= 1'b1;
		tread_ext <= ext;
		tread_addr <= a;
		@(posedge mclk);
		tread_req <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rst(input logic por, input logic p);
		@(posedge mclk);
		resetn <= 1'b0;
		por_n <= ~por;
		pin <= p;
		repeat (12) @(posedge mclk);
		chk({29'h0, pready, prog_strobe, tread_done}, 32'h0);
		resetn <= 1'b1;
		por_n <= 1'b1;
		repeat (4) @(posedge mclk);
	endtask
	task automatic stop_test;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		#2000000;
		fail_count++;
		stop_test();
	end
	initial begin
		{resetn, por_n, psel, penable, pwrite, pin, tread_req, tread_ext} = '0;
		paddr = '0;
		pwdata = '0;
		tread_addr = '0;
		fail_count = 0;
		num_checks = 0;
		rst(1'b1, 1'b0);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rdat & 32'h23, 32'h20);
		foreach (rows[i]) begin
			vread(rows[i][23:8]);
			chk(rdat, {24'h0, rows[i][7:0]});
			tr(1'b1, rows[i][23:8]);
			chk({30'h0, tread_done, tread_block}, 32'h2);
		end
		pin <= 1'b1;
		repeat (4) @(posedge mclk);
		chk({31'h0, acc_eff}, 32'h1);
		pin <= 1'b0;
		repeat (4) @(posedge mclk);
		chk({31'h0, acc_eff}, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		vread(16'h0040);
		chk(rdat, 32'h1A);
		prog(16'h1000, 8'h5A);
		vread(16'h0040);
		chk(rdat, 32'hBF);
		prog(16'h0081, 8'h3C);
		vread(16'h0081);
		chk(rdat, 32'h3C);
		prog(16'h1041, 8'h00);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rdat & 32'h10, 32'h10);
		apb(1'b1, 12'h00C, 32'h10);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rdat & 32'h10, 32'h0);
		prog(16'h1040, 8'h02);
		rst(1'b0, 1'b1);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rdat & 32'h1F, 32'h05);
		pin <= 1'b0;
		repeat (4) @(posedge mclk);
		chk({31'h0, acc_eff}, 32'h1);
		tr(1'b1, 16'h0100);
		chk({30'h0, tread_done, tread_block}, 32'h3);
		tr(1'b0, 16'h0100);
		chk({30'h0, tread_done, tread_block}, 32'h2);
		tr(1'b1, 16'h1000);
		chk({30'h0, tread_done, tread_block}, 32'h2);
		prog(16'h0081, 8'h00);
		vread(16'h0081);
		chk(rdat, 32'h3C);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rdat & 32'h10, 32'h10);
		rst(1'b1, 1'b0);
		prog(16'h1040, 8'h00);
		rst(1'b0, 1'b0);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rdat & 32'h0F, 32'h0B);
		vread(16'h0081);
		chk(rdat, 32'h0);
		tr(1'b1, 16'h0100);
		chk({30'h0, tread_done, tread_block}, 32'h3);
		prog(16'h0081, 8'h00);
		apb(1'b0, 12'h00C, 32'h0);
		chk(rdat & 32'h10, 32'h10);
		stop_test();
	end
endmodule
`default_nettype wire
